// file: verilog/supply_monitor.sv
// supply voltage monitor register block with an AXI4-Lite slave port
`timescale 1ns/10ps
module supply_monitor #(
    parameter int unsigned SETTLE_TIME_NS = supply_monitor_pkg::SETTLE_TIME_NS_DEFAULT
) (
    input wire logic clk,
    input wire logic arst_n,
    // axi4-lite write address
    input wire logic [supply_monitor_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [supply_monitor_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [supply_monitor_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [supply_monitor_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog comparator outputs, asynchronous
    input wire logic high_cmp_raw,
    input wire logic low_cmp_raw,
    // analog controls
    output logic high_threshold_select,
    output logic [1:0] low_threshold_select,
    output logic converter_tap_enable,
    output logic level_sense_enable,
    output logic divider_close,
    // module interrupt
    output logic monitor_irq_out
);

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [7:0] control_ff;
    logic [1:0] status_ff;
    logic [1:0] irq_enable_ff;
    logic [1:0] irq_flags_ff;
    logic [7:0] nxt_control;
    logic [1:0] nxt_status;
    logic [1:0] nxt_irq_enable;
    logic [1:0] nxt_irq_flags;

    // ------------------------------------------------------------------
    // address decode, shared by write and read paths
    // ------------------------------------------------------------------
    function automatic logic addr_is(
        input logic [supply_monitor_pkg::ADDR_W-1:0] addr,
        input logic [5:0] idx
    );
        // word index compare; byte lanes 1:0 of the address are ignored
        return addr[supply_monitor_pkg::ADDR_W-1:2] == idx;
    endfunction

    // anything past the last reserved word is answered with an error
    function automatic logic addr_mapped(input logic [supply_monitor_pkg::ADDR_W-1:0] addr);
        return addr[supply_monitor_pkg::ADDR_W-1:2] <= supply_monitor_pkg::IDX_LAST;
    endfunction

    // ------------------------------------------------------------------
    // write channel: address and data taken in either order
    // ------------------------------------------------------------------
    supply_monitor_pkg::wr_state_e wr_state_ff;
    supply_monitor_pkg::wr_state_e nxt_wr_state;
    logic aw_held_ff;
    logic w_held_ff;
    logic [supply_monitor_pkg::ADDR_W-1:0] aw_addr_ff;
    logic [7:0] w_byte_ff;
    logic w_lane_ff;
    logic [1:0] bresp_ff;
    logic nxt_aw_held;
    logic nxt_w_held;
    logic [1:0] nxt_bresp;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held_ff || aw_take;
    wire w_have = w_held_ff || w_take;
    wire wr_idle = (wr_state_ff == supply_monitor_pkg::WR_IDLE);
    wire wr_fire = wr_idle && aw_have && w_have;
    wire [supply_monitor_pkg::ADDR_W-1:0] wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
    wire [7:0] wr_byte = w_held_ff ? w_byte_ff : s_axi_wdata[7:0];
    wire wr_lane = w_held_ff ? w_lane_ff : s_axi_wstrb[0];
    wire wr_ok = wr_fire && wr_lane;

    // per-register write strobes; status and reserved words accept nothing
    wire wr_control = wr_ok && addr_is(wr_addr, supply_monitor_pkg::IDX_CONTROL);
    wire wr_enable = wr_ok && addr_is(wr_addr, supply_monitor_pkg::IDX_IRQ_ENABLE);
    wire wr_flags = wr_ok && addr_is(wr_addr, supply_monitor_pkg::IDX_IRQ_FLAGS);

    // write channel sequencing
    assign nxt_aw_held = !wr_fire && aw_have;
    assign nxt_w_held = !wr_fire && w_have;
    assign nxt_wr_state = wr_fire ? supply_monitor_pkg::WR_RESP :
                          ((!wr_idle && s_axi_bready) ? supply_monitor_pkg::WR_IDLE
                                                      : wr_state_ff);
    assign nxt_bresp = addr_mapped(wr_addr) ? supply_monitor_pkg::RESP_OKAY
                                            : supply_monitor_pkg::RESP_SLVERR;
    wire nxt_wr_idle = (nxt_wr_state == supply_monitor_pkg::WR_IDLE);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_state_ff <= supply_monitor_pkg::WR_IDLE;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bresp_ff <= supply_monitor_pkg::RESP_OKAY;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
        end else begin
            wr_state_ff <= nxt_wr_state;
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            // handshake outputs registered from the next state
            awready_ff <= nxt_wr_idle && !nxt_aw_held;
            wready_ff <= nxt_wr_idle && !nxt_w_held;
            bvalid_ff <= !nxt_wr_idle;
            if (wr_fire) begin
                bresp_ff <= nxt_bresp;
            end
        end
    end

    // capture a lone address or data beat until its partner arrives
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_addr_ff <= '0;
            w_byte_ff <= 8'h00;
            w_lane_ff <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                w_byte_ff <= s_axi_wdata[7:0];
                w_lane_ff <= s_axi_wstrb[0];
            end
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // ------------------------------------------------------------------
    // read channel: one beat, answered the cycle after the address
    // ------------------------------------------------------------------
    logic rvalid_ff;
    logic [7:0] rbyte_ff;
    logic [1:0] rresp_ff;
    logic arready_ff;
    logic [7:0] rd_byte;

    wire ar_take = s_axi_arvalid && !rvalid_ff;
    wire rd_control = addr_is(s_axi_araddr, supply_monitor_pkg::IDX_CONTROL);
    wire rd_status = addr_is(s_axi_araddr, supply_monitor_pkg::IDX_STATUS);
    wire rd_enable = addr_is(s_axi_araddr, supply_monitor_pkg::IDX_IRQ_ENABLE);
    wire rd_flags = addr_is(s_axi_araddr, supply_monitor_pkg::IDX_IRQ_FLAGS);

    // read mux; reserved words and unused bits return zero
    assign rd_byte = rd_control ? (control_ff & supply_monitor_pkg::CONTROL_MASK) :
                     rd_status ? {6'h00, status_ff} :
                     rd_enable ? {6'h00, irq_enable_ff} :
                     rd_flags ? {6'h00, irq_flags_ff} :
                     8'h00;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_ff <= 1'b0;
            rbyte_ff <= 8'h00;
            rresp_ff <= supply_monitor_pkg::RESP_OKAY;
            arready_ff <= 1'b1;
        end else begin
            if (ar_take) begin
                rvalid_ff <= 1'b1;
                arready_ff <= 1'b0;
                rbyte_ff <= rd_byte;
                rresp_ff <= addr_mapped(s_axi_araddr) ? supply_monitor_pkg::RESP_OKAY
                                                      : supply_monitor_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = {24'h000000, rbyte_ff};
    assign s_axi_rresp = rresp_ff;

    // ------------------------------------------------------------------
    // control and enable registers
    // ------------------------------------------------------------------
    // only implemented bits are stored
    assign nxt_control = wr_control ? (wr_byte & supply_monitor_pkg::CONTROL_MASK)
                                    : control_ff;
    assign nxt_irq_enable = wr_enable ? wr_byte[1:0] : irq_enable_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            control_ff <= supply_monitor_pkg::CONTROL_RESET;
            irq_enable_ff <= supply_monitor_pkg::PAIR_RESET;
        end else begin
            control_ff <= nxt_control;
            irq_enable_ff <= nxt_irq_enable;
        end
    end

    wire sense_on = control_ff[supply_monitor_pkg::CTRL_SENSE_BIT];
    wire tap_on = control_ff[supply_monitor_pkg::CTRL_TAP_BIT];

    // ------------------------------------------------------------------
    // analog control outputs, registered
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            high_threshold_select <= 1'b0;
            low_threshold_select <= 2'h0;
            converter_tap_enable <= 1'b0;
            level_sense_enable <= 1'b0;
            divider_close <= 1'b0;
        end else begin
            high_threshold_select <= nxt_control[supply_monitor_pkg::CTRL_HIGH_SEL_BIT];
            low_threshold_select <=
                nxt_control[supply_monitor_pkg::CTRL_LOW_SEL_LSB +: 2];
            converter_tap_enable <= nxt_control[supply_monitor_pkg::CTRL_TAP_BIT];
            level_sense_enable <= nxt_control[supply_monitor_pkg::CTRL_SENSE_BIT];
            divider_close <= nxt_control[supply_monitor_pkg::CTRL_TAP_BIT]
                          || nxt_control[supply_monitor_pkg::CTRL_SENSE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // settling window after an enable change
    // ------------------------------------------------------------------
    logic settled;
    wire enable_change = (nxt_control[supply_monitor_pkg::CTRL_SENSE_BIT] != sense_on)
                      || (nxt_control[supply_monitor_pkg::CTRL_TAP_BIT] != tap_on);

    settle_timer #(
        .SETTLE_TIME_NS(SETTLE_TIME_NS)
    ) u_settle (
        .clk(clk),
        .arst_n(arst_n),
        .restart(enable_change),
        .settled(settled)
    );

    // ------------------------------------------------------------------
    // comparator synchronisation and condition status
    // ------------------------------------------------------------------
    logic [1:0] cmp_sync;

    level_sync #(
        .WIDTH(2)
    ) u_cmp_sync (
        .clk(clk),
        .arst_n(arst_n),
        .async_in({high_cmp_raw, low_cmp_raw}),
        .sync_out(cmp_sync)
    );

    // forced low when sensing is off, frozen while settling
    assign nxt_status = !sense_on ? 2'h0 :
                        (!settled ? status_ff : cmp_sync);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status_ff <= supply_monitor_pkg::PAIR_RESET;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // ------------------------------------------------------------------
    // change flags: a set in the clear cycle wins
    // ------------------------------------------------------------------
    wire [1:0] status_change = nxt_status ^ status_ff;
    wire [1:0] flag_clear = wr_flags ? wr_byte[1:0] : 2'h0;

    assign nxt_irq_flags = status_change | (irq_flags_ff & ~flag_clear);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_flags_ff <= supply_monitor_pkg::PAIR_RESET;
        end else begin
            irq_flags_ff <= nxt_irq_flags;
        end
    end

    // ------------------------------------------------------------------
    // single interrupt output from the enabled flags
    // ------------------------------------------------------------------
    wire high_req = nxt_irq_flags[supply_monitor_pkg::HIGH_BIT]
                 && nxt_irq_enable[supply_monitor_pkg::HIGH_BIT];
    wire low_req = nxt_irq_flags[supply_monitor_pkg::LOW_BIT]
                && nxt_irq_enable[supply_monitor_pkg::LOW_BIT];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            monitor_irq_out <= 1'b0;
        end else begin
            monitor_irq_out <= high_req || low_req;
        end
    end

endmodule

// file: verilog/supply_monitor_pkg.sv
// constants shared by the supply monitor register block
package supply_monitor_pkg;

    // ------------------------------------------------------------------
    // bus geometry and responses
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_CONTROL = 6'h00;
    localparam logic [5:0] IDX_STATUS = 6'h01;
    localparam logic [5:0] IDX_IRQ_ENABLE = 6'h02;
    localparam logic [5:0] IDX_IRQ_FLAGS = 6'h03;
    localparam logic [5:0] IDX_RSVD_ZERO = 6'h04;
    localparam logic [5:0] IDX_RSVD_TEST = 6'h06;
    localparam logic [5:0] IDX_LAST = 6'h07;

    // ------------------------------------------------------------------
    // field positions and implemented-bit masks
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_HIGH_SEL_BIT = 6;
    localparam int unsigned CTRL_LOW_SEL_LSB = 4;
    localparam int unsigned CTRL_TAP_BIT = 3;
    localparam int unsigned CTRL_SENSE_BIT = 2;
    localparam int unsigned HIGH_BIT = 1;
    localparam int unsigned LOW_BIT = 0;
    localparam logic [7:0] CONTROL_MASK = 8'h7c;
    localparam logic [7:0] PAIR_MASK = 8'h03;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [1:0] PAIR_RESET = 2'h0;

    // ------------------------------------------------------------------
    // timing: analog settle time plus two bus cycles
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned SETTLE_TIME_NS_DEFAULT = 1000;
    localparam int unsigned EXTRA_BUS_CYC = 2;
    localparam int unsigned SETTLE_CNT_W = 12;

    // ------------------------------------------------------------------
    // write channel states (gray along idle -> respond)
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        WR_IDLE = 2'h0,
        WR_RESP = 2'h1
    } wr_state_e;

    // map a register index to its byte address
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [5:0] idx);
        return {idx, 2'h0};
    endfunction

endpackage

// file: verilog/level_sync.sv
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module level_sync #(
    parameter int unsigned WIDTH = 2
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------
    // one two-stage chain per bit; first stage feeds only the second
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic meta_ff;
            logic stable_ff;
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_ff <= 1'b0;
                    stable_ff <= 1'b0;
                end else begin
                    meta_ff <= async_in[g];
                    stable_ff <= meta_ff;
                end
            end
            assign sync_out[g] = stable_ff;
        end
    endgenerate

endmodule

// file: verilog/settle_timer.sv
// counts out the settling window after an analog enable changes
`timescale 1ns/10ps
module settle_timer #(
    parameter int unsigned SETTLE_TIME_NS = supply_monitor_pkg::SETTLE_TIME_NS_DEFAULT
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic restart,
    output logic settled
);

    // ------------------------------------------------------------------
    // window length: settle time rounded up, plus two bus cycles
    // ------------------------------------------------------------------
    localparam int unsigned SETTLE_CYC =
        (SETTLE_TIME_NS + supply_monitor_pkg::CLK_PERIOD_NS - 1)
        / supply_monitor_pkg::CLK_PERIOD_NS;
    localparam int unsigned RAW_LOAD = SETTLE_CYC + supply_monitor_pkg::EXTRA_BUS_CYC;
    localparam logic [supply_monitor_pkg::SETTLE_CNT_W-1:0] LOAD_VAL =
        supply_monitor_pkg::SETTLE_CNT_W'(RAW_LOAD);

    logic [supply_monitor_pkg::SETTLE_CNT_W-1:0] count_ff;
    logic [supply_monitor_pkg::SETTLE_CNT_W-1:0] nxt_count;
    wire busy = (count_ff != '0);

    // reload on every enable change, otherwise count down to zero
    assign nxt_count = restart ? LOAD_VAL : (busy ? count_ff - 1'b1 : count_ff);
    assign settled = !busy;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

endmodule

// file: tb/supply_analog_model.sv
// behavioural supply divider and comparators facing the monitor
`timescale 1ns/10ps
module supply_analog_model (
    input wire logic divider_close,
    input wire logic level_sense_enable,
    input wire logic [1:0] supply_level,
    output logic high_cmp_raw,
    output logic low_cmp_raw
);
    // comparators read zero unless the divider feeds them and level sensing is enabled
    assign high_cmp_raw = divider_close & level_sense_enable & supply_level[1];
    assign low_cmp_raw = divider_close & level_sense_enable & supply_level[0];
endmodule

// file: tb/supply_monitor_properties.sv
// assertions on the supply monitor ports
`timescale 1ns/10ps
module supply_monitor_properties #(
    parameter int unsigned SETTLE_TIME_NS = 1000
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic high_threshold_select,
    input wire logic [1:0] low_threshold_select,
    input wire logic converter_tap_enable,
    input wire logic level_sense_enable,
    input wire logic divider_close,
    input wire logic monitor_irq_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // requests taken at this edge
    wire wr_hit = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & s_axi_wstrb[0];
    wire rd_hit = s_axi_arvalid & s_axi_arready;
    wire [5:0] wr_idx = s_axi_awaddr[7:2];
    AST_CTRL_SELECTS: assert property (wr_hit && wr_idx == 6'h00 |=>
        {high_threshold_select, low_threshold_select} == $past(s_axi_wdata[6:4]))
        else $error("threshold selects do not follow control write");
    AST_CTRL_ENABLES: assert property (wr_hit && wr_idx == 6'h00 |=>
        {converter_tap_enable, level_sense_enable} == $past(s_axi_wdata[3:2]))
        else $error("enables do not follow control write");
    AST_DIVIDER: assert property (
        divider_close == (converter_tap_enable | level_sense_enable))
        else $error("divider path state wrong");
    AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    AST_READ_OKAY: assert property (rd_hit && s_axi_araddr < 8'h20 |->
        ##1 (s_axi_rvalid && s_axi_rresp == 2'h0))
        else $error("mapped read not answered okay");
    AST_READ_ERR: assert property (rd_hit && s_axi_araddr > 8'h1f |=> s_axi_rresp == 2'h2)
        else $error("unmapped read not refused");
    AST_RSVD_ZERO: assert property (rd_hit && s_axi_araddr[7:4] == 4'h1 |=> s_axi_rdata == 0)
        else $error("reserved word not zero");
    AST_IRQ_MASKED: assert property (
        wr_hit && wr_idx == 6'h02 && s_axi_wdata[1:0] == 2'h0 |=> !monitor_irq_out)
        else $error("interrupt raised while masked");
    COV_IRQ: cover property ($rose(monitor_irq_out));
    COV_W1C: cover property (wr_hit && wr_idx == 6'h03);
    COV_ERR: cover property (rd_hit && s_axi_araddr > 8'h1f);
endmodule

bind supply_monitor supply_monitor_properties #(.SETTLE_TIME_NS(SETTLE_TIME_NS)) props_u (.*);

// file: tb/supply_monitor_tb.sv
// self-checking bench for the supply monitor register block
`timescale 1ns/10ps
module supply_monitor_tb;
    // bus, analog and bookkeeping signals
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [1:0] supply_level = 2'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, low_threshold_select;
    logic [31:0] s_axi_rdata;
    logic high_cmp_raw, low_cmp_raw, high_threshold_select, converter_tap_enable;
    logic level_sense_enable, divider_close, monitor_irq_out;
    int err_total = 0;
    int num_checks = 0;

    // 50 ns clock
    always #25 clk = ~clk;

    supply_monitor #(.SETTLE_TIME_NS(200)) dut_u (.*);
    supply_analog_model model_u (.*);

    // ----------------------------------------------------------------
    // bus tasks and comparison
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one write; address and data released as each is taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, r});
    endtask

    // one read compared against the expected byte and response
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk(s_axi_rdata, {24'h0, d});
        chk({30'h0, s_axi_rresp}, {30'h0, r});
    endtask

    // prints counts and verdict, then stops
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++) rd(8'(4 * i), 8'h00, 2'h0);
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, {1'b0, i[0], i[1:0], 4'h0}, 2'h0);
            chk({29'h0, high_threshold_select, low_threshold_select}, {29'h0, i[0], i[1:0]});
        end
        wr(8'h00, 8'hff, 2'h0);
        rd(8'h00, 8'h7c, 2'h0);
        wr(8'h00, 8'h08, 2'h0);
        chk({29'h0, converter_tap_enable, level_sense_enable, divider_close}, 32'h5);
        wr(8'h00, 8'h04, 2'h0);
        chk({29'h0, converter_tap_enable, level_sense_enable, divider_close}, 32'h3);
        wr(8'h04, 8'hff, 2'h0);
        rd(8'h04, 8'h00, 2'h0);
        wr(8'h10, 8'hff, 2'h0);
        wr(8'h18, 8'hff, 2'h0);
        for (int i = 4; i < 8; i++) rd(8'(4 * i), 8'h00, 2'h0);
        wr(8'h40, 8'hff, 2'h2);
        rd(8'h40, 8'h00, 2'h2);
        wr(8'h0c, 8'hff, 2'h0);
        wr(8'h08, 8'hff, 2'h0);
        rd(8'h08, 8'h03, 2'h0);
        supply_level <= 2'h2;
        repeat (5) @(posedge clk);
        rd(8'h04, 8'h02, 2'h0);
        rd(8'h0c, 8'h02, 2'h0);
        chk({31'h0, monitor_irq_out}, 32'h1);
        wr(8'h08, 8'h01, 2'h0);
        chk({31'h0, monitor_irq_out}, 32'h0);
        wr(8'h0c, 8'h01, 2'h0);
        rd(8'h0c, 8'h02, 2'h0);
        wr(8'h0c, 8'h02, 2'h0);
        rd(8'h0c, 8'h00, 2'h0);
        supply_level <= 2'h1;
        repeat (5) @(posedge clk);
        rd(8'h04, 8'h01, 2'h0);
        rd(8'h0c, 8'h03, 2'h0);
        chk({31'h0, monitor_irq_out}, 32'h1);
        wr(8'h0c, 8'h03, 2'h0);
        wr(8'h00, 8'h00, 2'h0);
        rd(8'h04, 8'h00, 2'h0);
        rd(8'h0c, 8'h01, 2'h0);
        // masked write lane is answered but stores nothing
        wr(8'h08, 8'h00, 2'h0);
        s_axi_wstrb <= 4'h0;
        wr(8'h08, 8'hff, 2'h0);
        s_axi_wstrb <= 4'h1;
        rd(8'h08, 8'h00, 2'h0);
        // status holds its old value through the settle window
        supply_level <= 2'h2;
        wr(8'h00, 8'h04, 2'h0);
        rd(8'h04, 8'h00, 2'h0);
        rd(8'h04, 8'h00, 2'h0);
        repeat (5) @(posedge clk);
        rd(8'h04, 8'h02, 2'h0);
        rd(8'h0c, 8'h03, 2'h0);
        end_of_test();
    end

    // cuts a hung run short
    initial begin
        repeat (2000) @(posedge clk);
        err_total++;
        end_of_test();
    end
endmodule
